// [wrlvl_pkg.sv]
// Constants, timing counts and state encoding for the write-leveling engine.
// Assumes a 100 MHz controller clock; no other file defines these values.
package wrlvl_pkg;
  localparam int CLK_MHZ      = 100;
  localparam int SAMPLE_BATCH = 64;
  localparam int SAMPLE_CNT_W = 7;
  localparam int COARSE_TAPS  = 5;
  localparam int COARSE_W     = 4;
  localparam int FINE_W       = 9;
  localparam int FINE_LSB     = 0;
  localparam int COARSE_LSB   = 9;
  localparam int LVL_DLY_W    = 13;
  localparam int SETTLE_NS    = 50;
  localparam int MRS_NS       = 150;
  localparam int SETTLE_CYC   = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int MRS_CYC      = (MRS_NS * CLK_MHZ + 999) / 1000;
  localparam int WAIT_W       = 8;
  localparam int LINK_SKIP    = 4;
  localparam int LINK_RST_CYC = 24;
  localparam logic [3:0] ERR_NONE    = 4'h0;
  localparam logic [3:0] ERR_NO_ZERO = 4'h1;
  localparam logic [3:0] ERR_NO_ONE  = 4'h2;
  localparam logic [3:0] ERR_NO_LEFT = 4'h3;
  localparam logic [FINE_W-1:0] FINE_ZERO = 9'h000;
  localparam logic [FINE_W-1:0] FINE_ONE  = 9'h001;
  localparam logic [FINE_W-1:0] FINE_SAT  = 9'h1ff;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_MRS_ON  = 4'h1,
    ST_SETTLE  = 4'h3,
    ST_SAMPLE  = 4'h2,
    ST_WAIT    = 4'h6,
    ST_PROG    = 4'h7,
    ST_MRS_OFF = 4'h5,
    ST_DONE    = 4'h4,
    ST_ERR     = 4'hc
  } wl_state_t;
endpackage

// [ddr_write_leveling_calibration.sv]
// Write-leveling calibration engine for one DDR PHY, all bytes and ranks.
// Assumes feedback_i are DQ feedback pins sampled on link_clk_i while the
// strobe burst runs, and a controller outside that turns mrs_req_o into MRS.
`timescale 1ns/1ps
module ddr_write_leveling_calibration #(
  parameter int                         NB          = 4,
  parameter int                         NR          = 2,
  parameter int                         BW          = (NB > 1) ? $clog2(NB) : 1,
  parameter int                         RW          = (NR > 1) ? $clog2(NR) : 1,
  parameter logic [wrlvl_pkg::FINE_W-1:0] INIT_OFFSET = 9'h020,
  parameter logic [wrlvl_pkg::FINE_W-1:0] FINE_MAX    = 9'h1ff
) (
  input  wire logic                            ref_clk_i,
  input  wire logic                            rstn_i,
  input  wire logic                            link_clk_i,
  input  wire logic                            start_i,
  input  wire logic [RW-1:0]                   active_rank_i,
  input  wire logic [NB*wrlvl_pkg::FINE_W-1:0] deskew_i,
  input  wire logic [NB-1:0]                   feedback_i,
  output logic                                 busy_o,
  output logic                                 done_o,
  output logic [3:0]                           err_code_o,
  output logic [BW-1:0]                        err_byte_o,
  output logic                                 mrs_req_o,
  output logic                                 mrs_wl_on_o,
  output logic                                 strobe_data_decouple_mode_o,
  output logic                                 dqs_gate_en_o,
  output logic                                 leveling_mode_o,
  output logic [RW-1:0]                        sel_rank_o,
  output logic [BW-1:0]                        sel_byte_o,
  output logic [wrlvl_pkg::COARSE_W-1:0]       coarse_tap_o,
  output logic [wrlvl_pkg::FINE_W-1:0]         fine_tap_o,
  output logic [wrlvl_pkg::FINE_W-1:0]         final_fine_offset_o,
  output logic                                 lvl_dly_we_o,
  output logic [RW-1:0]                        lvl_dly_rank_o,
  output logic [BW-1:0]                        lvl_dly_byte_o,
  output logic [wrlvl_pkg::LVL_DLY_W-1:0]      per_rank_leveling_delay_o,
  output logic [NB*wrlvl_pkg::FINE_W-1:0]      output_fine_delay_line_o,
  output logic [NB*wrlvl_pkg::FINE_W-1:0]      lowest_common_fine_delay_o,
  output logic                                 dqs_burst_en_o
);
  localparam int FW = wrlvl_pkg::FINE_W;
  localparam int CW = wrlvl_pkg::COARSE_W;
  localparam int WW = wrlvl_pkg::WAIT_W;
  localparam logic [CW-1:0] COARSE_LAST = CW'(wrlvl_pkg::COARSE_TAPS - 1);
  localparam logic [BW-1:0] BYTE_LAST   = BW'(NB - 1);
  localparam logic [RW-1:0] RANK_LAST   = RW'(NR - 1);
  localparam logic [WW-1:0] SETTLE_LD   = WW'(wrlvl_pkg::SETTLE_CYC);
  localparam logic [WW-1:0] MRS_LD      = WW'(wrlvl_pkg::MRS_CYC);
  localparam logic [WW-1:0] HOLD_LD     = WW'(wrlvl_pkg::LINK_RST_CYC);
  localparam logic [wrlvl_pkg::SAMPLE_CNT_W-1:0] BATCH_LAST =
    wrlvl_pkg::SAMPLE_CNT_W'(wrlvl_pkg::SAMPLE_BATCH + wrlvl_pkg::LINK_SKIP - 1);
  localparam logic [wrlvl_pkg::SAMPLE_CNT_W-1:0] SKIP_LD =
    wrlvl_pkg::SAMPLE_CNT_W'(wrlvl_pkg::LINK_SKIP);

  // Deskew plus leveling delay, saturated at the line's range
  function automatic logic [FW-1:0] add_sat(input logic [FW-1:0] a, input logic [FW-1:0] b);
    logic [FW:0] s;
    s = {1'b0, a} + {1'b0, b};
    add_sat = s[FW] ? wrlvl_pkg::FINE_SAT : s[FW-1:0];
  endfunction

  // ---------------- Link domain: batch sampler ----------------
  logic                              lrst_meta, lrst_n;
  logic                              req_s1, req_s2, req_seen, next_req_seen;
  logic [NB-1:0]                     fb_s1, fb_s2;
  logic                              lbusy, next_lbusy;
  logic [wrlvl_pkg::SAMPLE_CNT_W-1:0] scnt, next_scnt;
  logic [NB-1:0]                     all0, next_all0, all1, next_all1;
  logic [NB-1:0]                     res_zero, next_res_zero, res_one, next_res_one;
  logic                              ack_tgl, next_ack_tgl;
  logic                              req_tgl, next_req_tgl;
  logic                              lrst_req, next_lrst_req;

  // Link reset comes from a stretched controller-domain request
  always_ff @(posedge link_clk_i) begin
    lrst_meta <= ~lrst_req;
    lrst_n    <= lrst_meta;
    req_s1    <= req_tgl;
    req_s2    <= req_s1;
    fb_s1     <= feedback_i;
    fb_s2     <= fb_s1;
  end

  always_comb begin
    next_req_seen = req_seen;
    next_lbusy    = lbusy;
    next_scnt     = scnt;
    next_all0     = all0;
    next_all1     = all1;
    next_res_zero = res_zero;
    next_res_one  = res_one;
    next_ack_tgl  = ack_tgl;
    if (!lbusy && (req_s2 != req_seen)) begin
      next_req_seen = req_s2;
      next_lbusy    = 1'b1;
      next_scnt     = '0;
      next_all0     = '1;
      next_all1     = '1;
    end else if (lbusy) begin
      if (scnt >= SKIP_LD) begin
        next_all0 = all0 & ~fb_s2;
        next_all1 = all1 & fb_s2;
      end
      next_scnt = scnt + 1'b1;
      if (scnt == BATCH_LAST) begin
        next_lbusy    = 1'b0;
        next_res_zero = next_all0;
        next_res_one  = next_all1;
        next_ack_tgl  = ~ack_tgl;
      end
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (!lrst_n) begin
      req_seen       <= 1'b0;
      lbusy          <= 1'b0;
      scnt           <= '0;
      all0           <= '0;
      all1           <= '0;
      res_zero       <= '0;
      res_one        <= '0;
      ack_tgl        <= 1'b0;
      dqs_burst_en_o <= 1'b0;
    end else begin
      req_seen       <= next_req_seen;
      lbusy          <= next_lbusy;
      scnt           <= next_scnt;
      all0           <= next_all0;
      all1           <= next_all1;
      res_zero       <= next_res_zero;
      res_one        <= next_res_one;
      ack_tgl        <= next_ack_tgl;
      dqs_burst_en_o <= next_lbusy;
    end
  end

  // ---------------- Controller domain: sequencer ----------------
  typedef enum logic [1:0] {
    PH_COARSE = 2'h0,
    PH_LEFT   = 2'h1,
    PH_RIGHT  = 2'h3
  } phase_t;

  wrlvl_pkg::wl_state_t state, next_state;
  phase_t               phase, next_phase;
  logic                 ack_s1, ack_s2, ack_seen, next_ack_seen;
  logic [WW-1:0]        wcnt, next_wcnt;
  logic [WW-1:0]        hold_cnt, next_hold_cnt;
  logic                 start_pend, next_start_pend;
  logic [RW-1:0]        next_sel_rank, next_dly_rank;
  logic [BW-1:0]        next_sel_byte, next_dly_byte, next_err_byte;
  logic [CW-1:0]        next_coarse;
  logic [CW-1:0]        coarse_last_stable_zero, next_coarse_last_stable_zero;
  logic                 found_zero, next_found_zero;
  logic [FW-1:0]        next_fine, offset, next_offset, next_final_off;
  logic [FW-1:0]        noise_left_edge, next_noise_left_edge;
  logic [FW-1:0]        noise_right_edge, next_noise_right_edge;
  logic [FW-1:0]        noise_center_setting;
  logic [FW:0]          edge_sum;
  logic                 got_zero, got_one;
  logic [3:0]           next_err_code;
  logic                 next_lvl, next_mrs_req, next_mrs_on, next_we;
  logic [wrlvl_pkg::LVL_DLY_W-1:0] next_dly;
  logic [FW-1:0]        fine_store [NR*NB];

  // Acknowledge synchroniser
  always_ff @(posedge ref_clk_i) begin
    ack_s1 <= ack_tgl;
    ack_s2 <= ack_s1;
  end

  assign got_zero = res_zero[sel_byte_o];
  assign got_one  = res_one[sel_byte_o];
  assign edge_sum = {1'b0, noise_left_edge} + {1'b0, fine_tap_o};
  assign noise_center_setting = edge_sum[FW:1];

  always_comb begin
    next_state                   = state;
    next_phase                   = phase;
    next_req_tgl                 = req_tgl;
    next_ack_seen                = ack_seen;
    next_wcnt                    = (wcnt != '0) ? wcnt - 1'b1 : wcnt;
    next_hold_cnt                = (hold_cnt != '0) ? hold_cnt - 1'b1 : hold_cnt;
    next_lrst_req                = (hold_cnt != '0);
    next_start_pend              = start_pend | start_i;
    next_sel_rank                = sel_rank_o;
    next_sel_byte                = sel_byte_o;
    next_coarse                  = coarse_tap_o;
    next_fine                    = fine_tap_o;
    next_offset                  = offset;
    next_final_off               = final_fine_offset_o;
    next_coarse_last_stable_zero = coarse_last_stable_zero;
    next_found_zero              = found_zero;
    next_noise_left_edge         = noise_left_edge;
    next_noise_right_edge        = noise_right_edge;
    next_err_code                = err_code_o;
    next_err_byte                = err_byte_o;
    next_we                      = 1'b0;
    next_dly                     = per_rank_leveling_delay_o;
    next_dly_rank                = lvl_dly_rank_o;
    next_dly_byte                = lvl_dly_byte_o;
    next_mrs_req                 = 1'b0;
    next_mrs_on                  = mrs_wl_on_o;
    case (state)
      wrlvl_pkg::ST_IDLE, wrlvl_pkg::ST_DONE, wrlvl_pkg::ST_ERR: begin
        next_ack_seen = ack_s2;
        if (start_pend && (hold_cnt == '0)) begin
          next_start_pend = 1'b0;
          next_state      = wrlvl_pkg::ST_MRS_ON;
          next_wcnt       = MRS_LD;
          next_sel_rank   = '0;
          next_sel_byte   = '0;
          next_coarse     = '0;
          next_fine       = wrlvl_pkg::FINE_ZERO;
          next_offset     = wrlvl_pkg::FINE_ZERO;
          next_found_zero = 1'b0;
          next_phase      = PH_COARSE;
          next_err_code   = wrlvl_pkg::ERR_NONE;
          next_mrs_req    = 1'b1;
          next_mrs_on     = 1'b1;
        end
      end
      wrlvl_pkg::ST_MRS_ON: begin
        if (wcnt == '0) begin
          next_state = wrlvl_pkg::ST_SETTLE;
          next_wcnt  = SETTLE_LD;
        end
      end
      wrlvl_pkg::ST_SETTLE: begin
        if (wcnt == '0) begin
          next_req_tgl = ~req_tgl;
          next_state   = wrlvl_pkg::ST_SAMPLE;
        end
      end
      wrlvl_pkg::ST_SAMPLE: begin
        if (ack_s2 != ack_seen) begin
          next_ack_seen = ack_s2;
          next_state    = wrlvl_pkg::ST_WAIT;
        end
      end
      wrlvl_pkg::ST_WAIT: begin
        next_state = wrlvl_pkg::ST_SETTLE;
        next_wcnt  = SETTLE_LD;
        case (phase)
          PH_COARSE: begin
            if (got_zero) begin
              next_coarse_last_stable_zero = coarse_tap_o;
              next_found_zero              = 1'b1;
              if (coarse_tap_o == COARSE_LAST) begin
                next_coarse     = '0;
                next_found_zero = 1'b0;
                next_offset     = (offset == wrlvl_pkg::FINE_ZERO) ? INIT_OFFSET : (offset >> 1);
                next_fine       = next_offset;
                if (offset == wrlvl_pkg::FINE_ONE) begin
                  next_state    = wrlvl_pkg::ST_ERR;
                  next_err_code = wrlvl_pkg::ERR_NO_ONE;
                  next_err_byte = sel_byte_o;
                end
              end else begin
                next_coarse = coarse_tap_o + 1'b1;
              end
            end else if (!found_zero) begin
              next_state    = wrlvl_pkg::ST_ERR;
              next_err_code = wrlvl_pkg::ERR_NO_ZERO;
              next_err_byte = sel_byte_o;
            end else begin
              next_coarse     = coarse_last_stable_zero;
              next_final_off  = offset;
              next_found_zero = 1'b0;
              next_phase      = PH_LEFT;
            end
          end
          PH_LEFT: begin
            if (got_zero) begin
              next_found_zero      = 1'b1;
              next_noise_left_edge = fine_tap_o;
              if (fine_tap_o == FINE_MAX) begin
                next_state    = wrlvl_pkg::ST_ERR;
                next_err_code = wrlvl_pkg::ERR_NO_ONE;
                next_err_byte = sel_byte_o;
              end else begin
                next_fine = fine_tap_o + 1'b1;
              end
            end else if (!found_zero) begin
              next_state    = wrlvl_pkg::ST_ERR;
              next_err_code = wrlvl_pkg::ERR_NO_LEFT;
              next_err_byte = sel_byte_o;
            end else if (got_one) begin
              next_noise_right_edge = fine_tap_o;
              next_fine             = noise_center_setting;
              next_state            = wrlvl_pkg::ST_PROG;
            end else if (fine_tap_o == FINE_MAX) begin
              next_state    = wrlvl_pkg::ST_ERR;
              next_err_code = wrlvl_pkg::ERR_NO_ONE;
              next_err_byte = sel_byte_o;
            end else begin
              next_phase = PH_RIGHT;
              next_fine  = fine_tap_o + 1'b1;
            end
          end
          default: begin
            if (got_one) begin
              next_noise_right_edge = fine_tap_o;
              next_fine             = noise_center_setting;
              next_state            = wrlvl_pkg::ST_PROG;
            end else if (fine_tap_o == FINE_MAX) begin
              next_state    = wrlvl_pkg::ST_ERR;
              next_err_code = wrlvl_pkg::ERR_NO_ONE;
              next_err_byte = sel_byte_o;
            end else begin
              next_fine = fine_tap_o + 1'b1;
            end
          end
        endcase
      end
      wrlvl_pkg::ST_PROG: begin
        next_we                                    = 1'b1;
        next_dly                                   = '0;
        next_dly[wrlvl_pkg::COARSE_LSB +: CW]      = coarse_tap_o;
        next_dly[wrlvl_pkg::FINE_LSB +: FW]        = fine_tap_o;
        next_dly_rank                              = sel_rank_o;
        next_dly_byte                              = sel_byte_o;
        next_coarse                                = '0;
        next_fine                                  = wrlvl_pkg::FINE_ZERO;
        next_offset                                = wrlvl_pkg::FINE_ZERO;
        next_found_zero                            = 1'b0;
        next_phase                                 = PH_COARSE;
        next_state                                 = wrlvl_pkg::ST_SETTLE;
        next_wcnt                                  = SETTLE_LD;
        if (sel_byte_o != BYTE_LAST) begin
          next_sel_byte = sel_byte_o + 1'b1;
        end else if (sel_rank_o != RANK_LAST) begin
          next_sel_byte = '0;
          next_sel_rank = sel_rank_o + 1'b1;
        end else begin
          next_coarse  = coarse_tap_o;
          next_fine    = fine_tap_o;
          next_state   = wrlvl_pkg::ST_MRS_OFF;
          next_wcnt    = MRS_LD;
          next_mrs_req = 1'b1;
          next_mrs_on  = 1'b0;
        end
      end
      wrlvl_pkg::ST_MRS_OFF: begin
        if (wcnt == '0) begin
          next_state = wrlvl_pkg::ST_DONE;
        end
      end
      default: begin
        next_state = wrlvl_pkg::ST_IDLE;
      end
    endcase
    next_lvl = (next_state != wrlvl_pkg::ST_IDLE) && (next_state != wrlvl_pkg::ST_DONE) &&
               (next_state != wrlvl_pkg::ST_ERR);
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      state                       <= wrlvl_pkg::ST_IDLE;
      phase                       <= PH_COARSE;
      req_tgl                     <= 1'b0;
      ack_seen                    <= 1'b0;
      wcnt                        <= '0;
      hold_cnt                    <= HOLD_LD;
      lrst_req                    <= 1'b1;
      start_pend                  <= 1'b0;
      sel_rank_o                  <= '0;
      sel_byte_o                  <= '0;
      coarse_tap_o                <= '0;
      fine_tap_o                  <= '0;
      offset                      <= '0;
      final_fine_offset_o         <= '0;
      coarse_last_stable_zero     <= '0;
      found_zero                  <= 1'b0;
      noise_left_edge             <= '0;
      noise_right_edge            <= '0;
      err_code_o                  <= wrlvl_pkg::ERR_NONE;
      err_byte_o                  <= '0;
      lvl_dly_we_o                <= 1'b0;
      per_rank_leveling_delay_o   <= '0;
      lvl_dly_rank_o              <= '0;
      lvl_dly_byte_o              <= '0;
      mrs_req_o                   <= 1'b0;
      mrs_wl_on_o                 <= 1'b0;
      busy_o                      <= 1'b0;
      done_o                      <= 1'b0;
      leveling_mode_o             <= 1'b0;
      strobe_data_decouple_mode_o <= 1'b0;
      dqs_gate_en_o               <= 1'b1;
    end else begin
      state                       <= next_state;
      phase                       <= next_phase;
      req_tgl                     <= next_req_tgl;
      ack_seen                    <= next_ack_seen;
      wcnt                        <= next_wcnt;
      hold_cnt                    <= next_hold_cnt;
      lrst_req                    <= next_lrst_req;
      start_pend                  <= next_start_pend;
      sel_rank_o                  <= next_sel_rank;
      sel_byte_o                  <= next_sel_byte;
      coarse_tap_o                <= next_coarse;
      fine_tap_o                  <= next_fine;
      offset                      <= next_offset;
      final_fine_offset_o         <= next_final_off;
      coarse_last_stable_zero     <= next_coarse_last_stable_zero;
      found_zero                  <= next_found_zero;
      noise_left_edge             <= next_noise_left_edge;
      noise_right_edge            <= next_noise_right_edge;
      err_code_o                  <= next_err_code;
      err_byte_o                  <= next_err_byte;
      lvl_dly_we_o                <= next_we;
      per_rank_leveling_delay_o   <= next_dly;
      lvl_dly_rank_o              <= next_dly_rank;
      lvl_dly_byte_o              <= next_dly_byte;
      mrs_req_o                   <= next_mrs_req;
      mrs_wl_on_o                 <= next_mrs_on;
      busy_o                      <= next_lvl;
      done_o                      <= (next_state == wrlvl_pkg::ST_DONE);
      leveling_mode_o             <= next_lvl;
      strobe_data_decouple_mode_o <= next_lvl;
      dqs_gate_en_o               <= ~next_lvl;
    end
  end

  // Per rank and byte fine store
  for (genvar i = 0; i < NR * NB; i++) begin : g_store
    logic [FW-1:0] next_entry;
    always_comb begin
      next_entry = fine_store[i];
      if (lvl_dly_we_o && ((int'(lvl_dly_rank_o) * NB + int'(lvl_dly_byte_o)) == i)) begin
        next_entry = per_rank_leveling_delay_o[wrlvl_pkg::FINE_LSB +: FW];
      end
    end
    always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
        fine_store[i] <= '0;
      end else begin
        fine_store[i] <= next_entry;
      end
    end
  end

  for (genvar b = 0; b < NB; b++) begin : g_byte
    logic [FW-1:0] lane_src, next_lane, next_low, new_fine;
    always_comb begin
      lane_src = fine_store[int'(active_rank_i) * NB + b];
      if (leveling_mode_o && (sel_byte_o == BW'(b))) begin
        lane_src = fine_tap_o;
      end else if (leveling_mode_o) begin
        lane_src = fine_store[int'(sel_rank_o) * NB + b];
      end
      next_lane = add_sat(deskew_i[b*FW +: FW], lane_src);
      new_fine  = per_rank_leveling_delay_o[wrlvl_pkg::FINE_LSB +: FW];
      next_low  = lowest_common_fine_delay_o[b*FW +: FW];
      if (lvl_dly_we_o && (lvl_dly_byte_o == BW'(b))) begin
        if ((lvl_dly_rank_o == '0) || (new_fine < next_low)) begin
          next_low = new_fine;
        end
      end
    end
    always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
        output_fine_delay_line_o[b*FW +: FW]   <= '0;
        lowest_common_fine_delay_o[b*FW +: FW] <= '0;
      end else begin
        output_fine_delay_line_o[b*FW +: FW]   <= next_lane;
        lowest_common_fine_delay_o[b*FW +: FW] <= next_low;
      end
    end
  end
endmodule

// [wl_check_asserts.sv]
// Checker on the leveling engine ports.
// Assumes binding onto the engine top module.
`timescale 1ns/1ps
module wl_check (
  input wire logic       ref_clk_i,
  input wire logic       rstn_i,
  input wire logic       busy_o,
  input wire logic       done_o,
  input wire logic [3:0] err_code_o,
  input wire logic       strobe_data_decouple_mode_o,
  input wire logic       dqs_gate_en_o,
  input wire logic       leveling_mode_o,
  input wire logic [3:0] coarse_tap_o,
  input wire logic [8:0] fine_tap_o,
  input wire logic       dqs_burst_en_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  a_coarse_tap_limit: assert property (coarse_tap_o < 4'h5)
    else $error("coarse tap beyond five");
  a_coarse_one_step: assert property (coarse_tap_o > $past(coarse_tap_o)
    |-> coarse_tap_o == $past(coarse_tap_o) + 4'h1) else $error("coarse jump");
  a_gating_off_lvl: assert property (leveling_mode_o
    |-> !dqs_gate_en_o && strobe_data_decouple_mode_o) else $error("gating in leveling");
  a_burst_in_lvl: assert property (dqs_burst_en_o |-> leveling_mode_o)
    else $error("burst outside leveling");
  a_settle_tap: assert property ($changed(coarse_tap_o) || $changed(fine_tap_o)
    |-> !dqs_burst_en_o) else $error("burst on tap change");
  a_done_restores: assert property ($rose(done_o)
    |-> dqs_gate_en_o && !strobe_data_decouple_mode_o) else $error("modes not restored");
  a_err_code_set: assert property (err_code_o < 4'h4) else $error("bad code");
  a_done_no_err: assert property (done_o |-> err_code_o == 4'h0 && !busy_o)
    else $error("done with error");
  a_err_stops: assert property (err_code_o != 4'h0 |-> !done_o [*4])
    else $error("done after error");
endmodule
bind ddr_write_leveling_calibration wl_check u_wl_check (.ref_clk_i(ref_clk_i),
  .rstn_i(rstn_i), .busy_o(busy_o), .done_o(done_o), .err_code_o(err_code_o),
  .strobe_data_decouple_mode_o(strobe_data_decouple_mode_o), .dqs_gate_en_o(dqs_gate_en_o),
  .leveling_mode_o(leveling_mode_o), .coarse_tap_o(coarse_tap_o), .fine_tap_o(fine_tap_o),
  .dqs_burst_en_o(dqs_burst_en_o));

// [sdram_wl_model.sv]
// Memory feedback model for write leveling.
// Assumes a coarse tap is 64 fine taps; noise band 8 taps wide.
`timescale 1ns/1ps
module sdram_wl_model #(parameter int NB = 2) (
  input  wire logic          link_clk_i,
  input  wire logic          burst_i,
  input  wire logic [3:0]    coarse_i,
  input  wire logic [8:0]    fine_i,
  input  wire logic [10:0]   edge_i,
  output logic      [NB-1:0] feedback_o
);
  logic [10:0] pos;
  logic        last = 1'b0;
  assign pos = {1'b0, coarse_i, 6'h00} + {2'h0, fine_i};
  always_ff @(posedge link_clk_i) begin
    if (!burst_i || (pos >= edge_i && pos < edge_i + 11'h008)) last <= ~last;
    else last <= (pos >= edge_i);
  end
  assign feedback_o = {NB{last}};
endmodule

// [tb_ddr_write_leveling_calibration.sv]
// Self-checking bench for the write-leveling engine.
// Assumes the memory model answers on the link clock.
`timescale 1ns/1ps
module tb_ddr_write_leveling_calibration;
  logic        ref_clk_i = 1'b0;
  logic        link_clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        start_i = 1'b0;
  logic        busy_o, done_o, lvl_dly_we_o, dqs_burst_en_o, dqs_gate_en_o;
  logic [3:0]  err_code_o, coarse_tap_o;
  logic [8:0]  fine_tap_o;
  logic [12:0] per_rank_leveling_delay_o, wdly;
  logic [1:0]  feedback;
  logic [0:0]  err_byte;
  logic [8:0]  ffo;
  logic [17:0] low, lanes;
  logic [10:0] edge_pos;
  int          n_mismatch = 0;
  int          total_checks = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  always #24 link_clk_i = ~link_clk_i;
  always @(posedge ref_clk_i) if (lvl_dly_we_o === 1'b1) wdly <= per_rank_leveling_delay_o;
  ddr_write_leveling_calibration #(.NB(2), .NR(2)) u_ddr_write_leveling_calibration (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .link_clk_i(link_clk_i), .start_i(start_i),
    .active_rank_i('0), .deskew_i('0), .feedback_i(feedback), .busy_o(busy_o),
    .done_o(done_o), .err_code_o(err_code_o), .err_byte_o(err_byte), .mrs_req_o(),
    .mrs_wl_on_o(),
    .strobe_data_decouple_mode_o(), .dqs_gate_en_o(dqs_gate_en_o), .leveling_mode_o(),
    .sel_rank_o(), .sel_byte_o(), .coarse_tap_o(coarse_tap_o), .fine_tap_o(fine_tap_o),
    .final_fine_offset_o(ffo), .lvl_dly_we_o(lvl_dly_we_o), .lvl_dly_rank_o(),
    .lvl_dly_byte_o(), .per_rank_leveling_delay_o(per_rank_leveling_delay_o),
    .output_fine_delay_line_o(lanes), .lowest_common_fine_delay_o(low),
    .dqs_burst_en_o(dqs_burst_en_o));
  sdram_wl_model #(.NB(2)) u_sdram_wl_model (.link_clk_i(link_clk_i),
    .burst_i(dqs_burst_en_o), .coarse_i(coarse_tap_o), .fine_i(fine_tap_o),
    .edge_i(edge_pos), .feedback_o(feedback));
  task automatic check(input string what, input logic [12:0] seen, input logic [12:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic run(input logic [10:0] pos);
    edge_pos = pos;
    rstn_i = 1'b0;
    repeat (2) @(posedge ref_clk_i);
    #1 rstn_i = 1'b1;
    @(posedge ref_clk_i);
    #1 start_i = 1'b1;
    @(posedge ref_clk_i);
    #1 start_i = 1'b0;
    for (int i = 0; i < 60000 && done_o !== 1'b1 && err_code_o === 4'h0; i++) begin
      @(posedge ref_clk_i);
      #1;
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    run(11'h000);
    check("err_code", {9'h0, err_code_o}, {9'h0, wrlvl_pkg::ERR_NO_ZERO});
    check("err_byte", {12'h0, err_byte}, 13'h0000);
    $display("test no_zero done");
    run(11'h7ff);
    check("err_code", {9'h0, err_code_o}, {9'h0, wrlvl_pkg::ERR_NO_ONE});
    $display("test no_one done");
    run(11'h096);
    check("done", {12'h0, done_o}, 13'h0001);
    check("err_code", {9'h0, err_code_o}, {9'h0, wrlvl_pkg::ERR_NONE});
    check("delay", wdly, {4'h2, 9'h019});
    check("gate", {12'h0, dqs_gate_en_o}, 13'h0001);
    check("offset", {4'h0, ffo}, 13'h0000);
    check("lowest", {4'h0, low[8:0]}, {4'h0, 9'h019});
    check("lane1", {4'h0, lanes[17:9]}, {4'h0, 9'h019});
    $display("test centre done");
    print_verdict;
  end
  initial begin
    repeat (100000) @(posedge ref_clk_i);
    n_mismatch++;
    print_verdict;
  end
endmodule
